// file: core/dcr_dev.sv
// Drive end: communications register bank of the serial slave
//
// Implementation choice: register access over the request and response link from the controller.
`timescale 1ns/1ns
module dcr_dev (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Link to the controller
    dcr_if.dev lnk,
    // Station address and drive parameters
    input wire logic [7:0] dev_addr_i,
    input wire logic [15:0] max_freq_i,
    input wire logic [dcr_pkg::OVR_W*dcr_pkg::SEL_W-1:0] out_sel_i,
    // Drive internals
    input wire logic [dcr_pkg::OVR_W-1:0] out_func_i,
    input wire logic [15:0] out_freq_i,
    input wire logic [15:0] v_calc_i,
    // Control terminals
    input wire logic [dcr_pkg::RUN_W-1:0] term_in_i,
    // Effective drive controls
    output logic [dcr_pkg::RUN_W-1:0] ctl_word_o,
    output logic [dcr_pkg::OVR_W-1:0] out_term_o,
    output logic [15:0] freq_cmd_o,
    output logic [15:0] v_out_o,
    output logic [15:0] skip_freq_one_o
);
    import dcr_pkg::*;

    // ------------------------------------------------------------
    // Scaling helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] sat16(input logic [31:0] v);
        return (v > 32'h0000ffff) ? 16'hffff : v[15:0];
    endfunction

    function automatic logic [15:0] bcast_to_hz(input logic [15:0] val,
                                                input logic [15:0] fmax);
        logic [31:0] p;
        p = (32'(val) * 32'(fmax) + BCAST_HALF) / BCAST_FULL;
        return sat16(p);
    endfunction

    function automatic logic [15:0] comm_to_hz(input logic [15:0] unit,
                                               input logic [15:0] val,
                                               input logic [15:0] fmax);
        logic [31:0] p;
        p = 32'(val);
        case (unit)
            UNIT_HZ001: p = 32'(val);
            UNIT_HZ01: p = 32'(val) * TEN;
            default: p = (32'(val) * 32'(fmax) + BCAST_HALF) / BCAST_FULL;
        endcase
        return sat16(p);
    endfunction

    function automatic logic [15:0] hz_to_comm(input logic [15:0] unit,
                                               input logic [15:0] f,
                                               input logic [15:0] fmax);
        logic [31:0] p;
        p = 32'(f);
        case (unit)
            UNIT_HZ001: p = 32'(f);
            UNIT_HZ01: p = (32'(f) + 32'h00000005) / TEN;
            default: p = (fmax == 16'h0000) ? 32'h00000000 :
                         (32'(f) * BCAST_FULL) / 32'(fmax);
        endcase
        return sat16(p);
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [RUN_W-1:0] run_q;
    logic [15:0] freq_raw_q;
    logic [15:0] freq_hz_q;
    logic [15:0] vgain_q;
    logic [OVR_W-1:0] ovr_q;
    logic [15:0] skip1_q;
    logic [15:0] unit_q;
    logic [RUN_W-1:0] term_s1_q;
    logic [RUN_W-1:0] term_s2_q;
    logic rsp_vld_q;
    logic [7:0] rsp_func_q;
    logic [15:0] rsp_data_q;
    logic [7:0] err_code;
    logic [15:0] rd_data;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    wire addr_ok = dev_addr_i >= ADDR_MIN && dev_addr_i <= ADDR_MAX;
    wire is_mine = lnk.req_vld && addr_ok && lnk.req_slave == dev_addr_i;
    wire is_bcast = lnk.req_vld && lnk.req_slave == ADDR_BCAST;
    wire is_rd = lnk.req_func == FN_READ;
    wire is_wr = lnk.req_func == FN_WRITE;
    wire [15:0] rq = lnk.req_reg;
    wire [15:0] wd = lnk.req_data;
    wire wr_known = rq == REG_RUN || rq == REG_FREQ || rq == REG_VGAIN ||
                    rq == REG_OVR || rq == REG_SKIP1 || rq == REG_UNIT;
    wire rd_known = wr_known || rq == REG_FREF_MON || rq == REG_FOUT_MON;
    wire vgain_bad = rq == REG_VGAIN && (wd < VGAIN_MIN || wd > VGAIN_MAX);
    wire unit_bad = rq == REG_UNIT && wd > UNIT_MAX;
    wire wr_ok = is_mine && is_wr && err_code == ERR_NONE;
    wire bc_run = is_bcast && is_wr && rq == REG_RUN;
    wire bc_freq = is_bcast && is_wr && rq == REG_FREQ;

    // Rejection reason, function first, then register, then value
    always_comb begin
        if (!is_rd && !is_wr) begin
            err_code = ERR_FUNC;
        end else if (is_rd ? !rd_known : !wr_known) begin
            err_code = ERR_REG;
        end else if (is_wr && (vgain_bad || unit_bad)) begin
            err_code = ERR_DATA;
        end else begin
            err_code = ERR_NONE;
        end
    end

    // Read data: stored communication values and the two frequency monitors, not terminals
    always_comb begin
        case (rq)
            REG_RUN: rd_data = {5'h00, run_q};
            REG_FREQ: rd_data = freq_raw_q;
            REG_VGAIN: rd_data = vgain_q;
            REG_OVR: rd_data = {13'h0000, ovr_q};
            REG_SKIP1: rd_data = skip1_q;
            REG_UNIT: rd_data = unit_q;
            REG_FREF_MON: rd_data = hz_to_comm(unit_q, freq_hz_q,
                                               max_freq_i);
            REG_FOUT_MON: rd_data = hz_to_comm(unit_q, out_freq_i,
                                               max_freq_i);
            default: rd_data = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run_q <= RST_RUN;
        end else if (wr_ok && rq == REG_RUN) begin
            run_q <= wd[RUN_W-1:0];
        end else if (bc_run) begin
            run_q[BCAST_RUN_W-1:0] <= wd[BCAST_RUN_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            freq_raw_q <= RST_FREQ;
            freq_hz_q <= RST_FREQ;
        end else if (wr_ok && rq == REG_FREQ) begin
            freq_raw_q <= wd;
            freq_hz_q <= comm_to_hz(unit_q, wd, max_freq_i);
        end else if (bc_freq) begin
            freq_raw_q <= wd;
            freq_hz_q <= bcast_to_hz(wd, max_freq_i);
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vgain_q <= RST_VGAIN;
            ovr_q <= RST_OVR;
            skip1_q <= RST_SKIP1;
            unit_q <= RST_UNIT;
        end else if (wr_ok) begin
            if (rq == REG_VGAIN) begin
                vgain_q <= wd;
            end
            if (rq == REG_OVR) begin
                ovr_q <= wd[OVR_W-1:0];
            end
            if (rq == REG_SKIP1) begin
                skip1_q <= wd;
            end
            if (rq == REG_UNIT) begin
                unit_q <= wd;
            end
        end
    end

    // ------------------------------------------------------------
    // Response, unicast only
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rsp_vld_q <= 1'b0;
            rsp_func_q <= 8'h00;
            rsp_data_q <= 16'h0000;
        end else begin
            rsp_vld_q <= is_mine;
            if (is_mine && err_code != ERR_NONE) begin
                rsp_func_q <= lnk.req_func | FN_ERR_FLAG;
                rsp_data_q <= {8'h00, err_code};
            end else if (is_mine) begin
                rsp_func_q <= lnk.req_func;
                rsp_data_q <= is_rd ? rd_data : wd;
            end
        end
    end

    assign lnk.rsp_vld = rsp_vld_q;
    assign lnk.rsp_func = rsp_func_q;
    assign lnk.rsp_data = rsp_data_q;

    // ------------------------------------------------------------
    // Drive side outputs
    // ------------------------------------------------------------
    logic [OVR_W-1:0] out_next;
    logic [31:0] v_prod;

    always_comb begin
        for (int i = 0; i < OVR_W; i++) begin
            out_next[i] = (out_sel_i[i*SEL_W +: SEL_W] == OUTSEL_COMM) ?
                          ovr_q[i] : out_func_i[i];
        end
    end

    assign v_prod = (32'(v_calc_i) * 32'(vgain_q)) / 32'(VGAIN_ONE);

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            term_s1_q <= '0;
            term_s2_q <= '0;
            ctl_word_o <= '0;
            out_term_o <= '0;
            freq_cmd_o <= 16'h0000;
            v_out_o <= 16'h0000;
            skip_freq_one_o <= 16'h0000;
        end else begin
            term_s1_q <= term_in_i;
            term_s2_q <= term_s1_q;
            ctl_word_o <= run_q | term_s2_q;
            out_term_o <= out_next;
            freq_cmd_o <= freq_hz_q;
            v_out_o <= sat16(v_prod);
            skip_freq_one_o <= skip1_q;
        end
    end
endmodule

// file: core/dcr_pkg.sv
// Shared constants and types of the drive serial register bank
package dcr_pkg;
    // ------------------------------------------------------------
    // Register numbers on the drive link
    // ------------------------------------------------------------
    localparam logic [15:0] REG_RUN = 16'h0001;
    localparam logic [15:0] REG_FREQ = 16'h0002;
    localparam logic [15:0] REG_VGAIN = 16'h0003;
    localparam logic [15:0] REG_OVR = 16'h0009;
    localparam logic [15:0] REG_IO_LAST = 16'h000f;
    localparam logic [15:0] REG_FREF_MON = 16'h0023;
    localparam logic [15:0] REG_FOUT_MON = 16'h0024;
    localparam logic [15:0] REG_SKIP1 = 16'h0153;
    localparam logic [15:0] REG_UNIT = 16'h0198;
    // ------------------------------------------------------------
    // Addresses, function codes, error codes
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_BCAST = 8'h00;
    localparam logic [7:0] ADDR_MIN = 8'h01;
    localparam logic [7:0] ADDR_MAX = 8'h20;
    localparam logic [7:0] FN_READ = 8'h03;
    localparam logic [7:0] FN_WRITE = 8'h10;
    localparam logic [7:0] FN_ERR_FLAG = 8'h80;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_FUNC = 8'h01;
    localparam logic [7:0] ERR_REG = 8'h02;
    localparam logic [7:0] ERR_DATA = 8'h21;
    // ------------------------------------------------------------
    // Field layout and value ranges
    // ------------------------------------------------------------
    localparam int RUN_W = 11;
    localparam int BCAST_RUN_W = 4;
    localparam int OVR_W = 3;
    localparam int SEL_W = 8;
    localparam logic [15:0] RUN_USED_MASK = 16'h07ff;
    localparam logic [15:0] VGAIN_ONE = 16'h03e8;
    localparam logic [15:0] VGAIN_MIN = 16'h0014;
    localparam logic [15:0] VGAIN_MAX = 16'h07d0;
    localparam logic [31:0] BCAST_FULL = 32'h00007530;
    localparam logic [31:0] BCAST_HALF = 32'h00003a98;
    localparam logic [31:0] TEN = 32'h0000000a;
    localparam logic [15:0] UNIT_HZ001 = 16'h0000;
    localparam logic [15:0] UNIT_HZ01 = 16'h0001;
    localparam logic [15:0] UNIT_MAX = 16'h0003;
    localparam logic [7:0] OUTSEL_COMM = 8'h12;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [10:0] RST_RUN = 11'h000;
    localparam logic [15:0] RST_FREQ = 16'h0000;
    localparam logic [15:0] RST_VGAIN = 16'h03e8;
    localparam logic [2:0] RST_OVR = 3'h0;
    localparam logic [15:0] RST_SKIP1 = 16'h0000;
    localparam logic [15:0] RST_UNIT = 16'h0000;
    // ------------------------------------------------------------
    // Controller Wishbone map (byte addresses) and status bits
    // ------------------------------------------------------------
    localparam logic [7:0] WB_REGNO = 8'h00;
    localparam logic [7:0] WB_WDATA = 8'h04;
    localparam logic [7:0] WB_CMD = 8'h08;
    localparam logic [7:0] WB_STAT = 8'h0c;
    localparam logic [7:0] WB_RDATA = 8'h10;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ERR = 2;
    localparam int ST_TMO = 3;
    localparam int ST_REFUSED = 4;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int RSP_TIMEOUT_NS = 20000;
    localparam int RSP_TIMEOUT_CYC = RSP_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam logic [7:0] RSP_TIMEOUT_CNT = 8'(RSP_TIMEOUT_CYC);

    typedef enum logic [1:0] {
        DCR_IDLE = 2'b00,
        DCR_SEND = 2'b01,
        DCR_WAIT = 2'b10
    } dcr_mst_state_t;
endpackage

// file: core/dcr_if.sv
// Request and response link between drive controller and drive
`timescale 1ns/1ns
interface dcr_if;
    logic req_vld;
    logic [7:0] req_slave;
    logic [7:0] req_func;
    logic [15:0] req_reg;
    logic [15:0] req_data;
    logic rsp_vld;
    logic [7:0] rsp_func;
    logic [15:0] rsp_data;

    modport dev (
        input req_vld, req_slave, req_func, req_reg, req_data,
        output rsp_vld, rsp_func, rsp_data
    );
    modport mst (
        output req_vld, req_slave, req_func, req_reg, req_data,
        input rsp_vld, rsp_func, rsp_data
    );
endinterface

// file: core/dcr_master.sv
// Controller end: Wishbone-driven master of the drive link
`timescale 1ns/1ns
module dcr_master (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Link to the drive
    dcr_if.mst lnk
);
    import dcr_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    dcr_mst_state_t state_q;
    logic [15:0] regno_q;
    logic [15:0] wdata_q;
    logic [7:0] slave_q;
    logic [7:0] func_q;
    logic [7:0] rsp_func_q;
    logic [15:0] rsp_data_q;
    logic done_q;
    logic err_q;
    logic tmo_q;
    logic refused_q;
    logic [7:0] tmo_cnt_q;
    logic ack_q;
    logic [31:0] dat_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    wire bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    wire lanes_ok = wb_sel_i[1:0] == 2'b11;
    wire wr_regno = bus_wr && wb_adr_i == WB_REGNO && lanes_ok;
    wire wr_wdata = bus_wr && wb_adr_i == WB_WDATA && lanes_ok;
    wire wr_cmd = bus_wr && wb_adr_i == WB_CMD && lanes_ok;
    wire wr_stat = bus_wr && wb_adr_i == WB_STAT && wb_sel_i[0];
    wire busy = state_q != DCR_IDLE;
    wire start = wr_cmd && !busy;
    wire [7:0] cmd_slave = wb_dat_i[7:0];
    wire [7:0] cmd_func = wb_dat_i[15:8];
    wire io_unused = regno_q <= REG_IO_LAST && regno_q != REG_RUN &&
                     regno_q != REG_FREQ && regno_q != REG_VGAIN &&
                     regno_q != REG_OVR;
    wire refuse = start && cmd_func == FN_WRITE && io_unused;
    wire launch = start && !refuse;
    wire is_bc = slave_q == ADDR_BCAST;
    wire got_rsp = state_q == DCR_WAIT && lnk.rsp_vld;
    wire timed_out = state_q == DCR_WAIT && !lnk.rsp_vld &&
                     tmo_cnt_q == RSP_TIMEOUT_CNT;
    wire finish = got_rsp || timed_out ||
                  (state_q == DCR_SEND && is_bc);
    wire [4:0] stat_w = {refused_q, tmo_q, err_q, done_q, busy};

    logic [31:0] rd_mux;
    always_comb begin
        case (wb_adr_i)
            WB_REGNO: rd_mux = {16'h0000, regno_q};
            WB_WDATA: rd_mux = {16'h0000, wdata_q};
            WB_CMD: rd_mux = {16'h0000, func_q, slave_q};
            WB_STAT: rd_mux = {27'h0000000, stat_w};
            WB_RDATA: rd_mux = {8'h00, rsp_func_q, rsp_data_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------
    // Wishbone answer, one cycle after the request
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= bus_req;
            if (bus_req) begin
                dat_q <= rd_mux;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ------------------------------------------------------------
    // Order registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            regno_q <= 16'h0000;
            wdata_q <= 16'h0000;
            slave_q <= 8'h00;
            func_q <= 8'h00;
        end else begin
            if (wr_regno && !busy) begin
                regno_q <= wb_dat_i[15:0];
            end
            if (wr_wdata && !busy) begin
                wdata_q <= wb_dat_i[15:0];
            end
            if (start) begin
                slave_q <= cmd_slave;
                func_q <= cmd_func;
            end
        end
    end

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= DCR_IDLE;
            tmo_cnt_q <= 8'h00;
        end else begin
            case (state_q)
                DCR_IDLE: state_q <= launch ? DCR_SEND : DCR_IDLE;
                DCR_SEND: state_q <= is_bc ? DCR_IDLE : DCR_WAIT;
                DCR_WAIT: state_q <= finish ? DCR_IDLE : DCR_WAIT;
                default: state_q <= DCR_IDLE;
            endcase
            tmo_cnt_q <= (state_q == DCR_WAIT) ? tmo_cnt_q + 8'h01 : 8'h00;
        end
    end

    // Request drive toward the link, one cycle in SEND
    assign lnk.req_vld = state_q == DCR_SEND;
    assign lnk.req_slave = slave_q;
    assign lnk.req_func = func_q;
    assign lnk.req_reg = regno_q;
    assign lnk.req_data = (regno_q == REG_RUN) ?
                          (wdata_q & RUN_USED_MASK) : wdata_q;

    // ------------------------------------------------------------
    // Response capture and sticky status, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rsp_func_q <= 8'h00;
            rsp_data_q <= 16'h0000;
            done_q <= 1'b0;
            err_q <= 1'b0;
            tmo_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            if (got_rsp) begin
                rsp_func_q <= lnk.rsp_func;
                rsp_data_q <= lnk.rsp_data;
            end
            done_q <= finish || (done_q && !(wr_stat && wb_dat_i[ST_DONE]));
            err_q <= (got_rsp && lnk.rsp_func[7]) ||
                     (err_q && !(wr_stat && wb_dat_i[ST_ERR]));
            tmo_q <= timed_out ||
                     (tmo_q && !(wr_stat && wb_dat_i[ST_TMO]));
            refused_q <= refuse ||
                         (refused_q && !(wr_stat && wb_dat_i[ST_REFUSED]));
        end
    end
endmodule

// file: dv/dcr_checker.sv
// Link checker between drive controller and drive
`timescale 1ns/1ns
module dcr_checker (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Link signals
    input wire logic req_vld,
    input wire logic [7:0] req_slave,
    input wire logic [7:0] req_func,
    input wire logic [15:0] req_reg,
    input wire logic [15:0] req_data,
    input wire logic rsp_vld,
    input wire logic [7:0] rsp_func,
    input wire logic [15:0] rsp_data
);
    import dcr_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    sequence uni_s(f, r);
        req_vld && req_slave != ADDR_BCAST && req_func == f && req_reg == r;
    endsequence
    bcast_quiet_a: assert property (
        req_vld && req_slave == ADDR_BCAST |=> !rsp_vld) else $error("bcast");
    rsp_cause_a: assert property (
        rsp_vld |-> $past(req_vld)) else $error("no cause");
    rsp_pulse_a: assert property (
        rsp_vld |=> !rsp_vld) else $error("long answer");
    run_upper_a: assert property (
        uni_s(FN_READ, REG_RUN) ##1 rsp_vld |-> rsp_data[15:11] == 5'h00)
        else $error("run upper bits");
    bad_func_a: assert property (
        req_vld && req_slave != ADDR_BCAST && req_func != FN_READ &&
        req_func != FN_WRITE ##1 rsp_vld |-> rsp_data == {8'h00, ERR_FUNC}
        && rsp_func == ($past(req_func) | FN_ERR_FLAG)) else $error("func");
    bad_reg_a: assert property (
        uni_s(FN_READ, 16'h0004) ##1 rsp_vld |-> rsp_func == 8'h83 &&
        rsp_data == {8'h00, ERR_REG}) else $error("unused reg");
    gain_range_a: assert property (
        uni_s(FN_WRITE, REG_VGAIN) ##0 (req_data < VGAIN_MIN ||
        req_data > VGAIN_MAX) ##1 rsp_vld |-> rsp_func == 8'h90 &&
        rsp_data == {8'h00, ERR_DATA}) else $error("gain range");
    write_echo_a: assert property (
        uni_s(FN_WRITE, REG_FREQ) ##1 rsp_vld |-> rsp_func == FN_WRITE &&
        rsp_data == $past(req_data)) else $error("echo");
endmodule

// file: dv/drive_comm_register_map_test.sv
// Bench of controller and drive joined over the link
`timescale 1ns/1ns
module drive_comm_register_map_test;
    import dcr_pkg::*;
    logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
    logic we = 1'b0, ack;
    logic [7:0] adr = 8'h00, dev_addr_i = 8'h01;
    logic [31:0] wdat = 32'h0, rdat, wbo, st, p, rnd = 32'h00017b06;
    logic [15:0] max_freq_i = 16'h0, v_calc_i = 16'h0, g, v;
    logic [15:0] freq_cmd_o, v_out_o, skip_freq_one_o;
    logic [23:0] out_sel_i = {8'h00, 8'h13, OUTSEL_COMM};
    logic [2:0] out_func_i = 3'h0, out_term_o;
    logic [10:0] term_in_i = 11'h0, r, ctl_word_o;
    logic [23:0] notes[$];
    int bad_count = 0, num_checks = 0;
    dcr_if lnk();
    dcr_dev i_dcr_dev (.clk_sys_i, .sys_rst_i, .lnk(lnk), .dev_addr_i,
        .max_freq_i, .out_sel_i, .out_func_i, .out_freq_i(v_calc_i),
        .v_calc_i, .term_in_i, .ctl_word_o, .out_term_o, .freq_cmd_o,
        .v_out_o, .skip_freq_one_o);
    dcr_master i_dcr_master (.clk_sys_i, .sys_rst_i, .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(wbo), .wb_ack_o(ack), .lnk(lnk));
    dcr_checker i_dcr_checker (.clk_sys_i, .sys_rst_i,
        .req_vld(lnk.req_vld), .req_slave(lnk.req_slave),
        .req_func(lnk.req_func), .req_reg(lnk.req_reg),
        .req_data(lnk.req_data), .rsp_vld(lnk.rsp_vld),
        .rsp_func(lnk.rsp_func), .rsp_data(lnk.rsp_data));
    always #50 clk_sys_i = ~clk_sys_i;
    function automatic logic [31:0] nxt(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic cmp(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input [31:0] d);
        @(posedge clk_sys_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk_sys_i); while (ack !== 1'b1);
        rdat = wbo;
        {cyc, stb} <= 2'b00;
    endtask
    // One link transfer; a note is queued when an answer is due
    task automatic op(input logic [7:0] s, f, input logic [15:0] rg, d,
                      input logic a, input logic [23:0] e);
        wb(1'b1, WB_REGNO, {16'h0, rg});
        wb(1'b1, WB_WDATA, {16'h0, d});
        if (a) notes.push_back(e);
        wb(1'b1, WB_CMD, {16'h0, f, s});
        for (int i = 0; i < 400; i++) begin
            wb(1'b0, WB_STAT, 32'h0);
            if (rdat[ST_BUSY] === 1'b0) break;
        end
        st = rdat;
        cmp("busy", 32'h0, 32'(st[ST_BUSY]));
        if (a) wb(1'b0, WB_RDATA, 32'h0);
        if (a) cmp("rdata", {8'h00, e}, rdat);
        wb(1'b1, WB_STAT, 32'h1e);
    endtask
    always @(posedge clk_sys_i) begin
        if (lnk.rsp_vld === 1'b1) begin
            if (notes.size() == 0) cmp("answer", 32'h0, 32'h1);
            else cmp("answer", {8'h00, notes.pop_front()},
                {8'h00, lnk.rsp_func, lnk.rsp_data});
        end
    end
    initial begin
        #4000000;
        bad_count++;
        conclude();
    end
    initial begin
        rnd = nxt(rnd);
        @(posedge clk_sys_i);
        term_in_i <= rnd[15:5];
        dev_addr_i <= 8'(rnd[4:0]) + 8'h01;
        {v_calc_i, out_func_i} <= {rnd[31:16], rnd[18:16]};
        max_freq_i <= rnd[15:0];
        repeat (5) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        op(dev_addr_i, FN_READ, REG_VGAIN, 16'h0, 1, {FN_READ, RST_VGAIN});
        rnd = nxt(rnd);
        r = rnd[10:0];
        op(dev_addr_i, FN_WRITE, REG_RUN, {5'h1f, r}, 1, {FN_WRITE, 5'h0, r});
        op(dev_addr_i, FN_READ, REG_RUN, 16'h0, 1, {FN_READ, 5'h0, r});
        cmp("ctl", 32'(r | term_in_i), 32'(ctl_word_o));
        op(ADDR_BCAST, FN_WRITE, REG_RUN, 16'hfff5, 0, 24'h0);
        cmp("bctl", 32'({r[10:4], 4'h5} | term_in_i), 32'(ctl_word_o));
        op(ADDR_BCAST, FN_READ, REG_RUN, 16'h0, 0, 24'h0);
        g = VGAIN_MIN + 16'(rnd % 32'h7bd);
        op(dev_addr_i, FN_WRITE, REG_VGAIN, g, 1, {FN_WRITE, g});
        p = 32'(v_calc_i) * 32'(g) / 32'h3e8;
        cmp("vout", p > 32'hffff ? 32'hffff : p, 32'(v_out_o));
        for (int i = 0; i < 2; i++) op(dev_addr_i, FN_WRITE, REG_VGAIN,
            i ? VGAIN_MAX + 16'h1 : VGAIN_MIN - 16'h1, 1,
            {8'h90, 8'h00, ERR_DATA});
        op(ADDR_BCAST, FN_WRITE, REG_VGAIN, VGAIN_ONE, 0, 24'h0);
        op(dev_addr_i, FN_READ, REG_VGAIN, 16'h0, 1, {FN_READ, g});
        v = rnd[31:16];
        op(dev_addr_i, FN_WRITE, REG_FREQ, v, 1, {FN_WRITE, v});
        cmp("fcmd", 32'(v), 32'(freq_cmd_o));
        op(dev_addr_i, FN_READ, REG_FREF_MON, 16'h0, 1, {FN_READ, v});
        op(dev_addr_i, FN_WRITE, REG_UNIT, UNIT_HZ01, 1,
            {FN_WRITE, UNIT_HZ01});
        v = {4'h0, rnd[11:0]};
        op(dev_addr_i, FN_WRITE, REG_FREQ, v, 1, {FN_WRITE, v});
        cmp("fcmd", 32'(v) * TEN, 32'(freq_cmd_o));
        op(dev_addr_i, FN_READ, REG_FREQ, 16'h0, 1, {FN_READ, v});
        op(dev_addr_i, FN_READ, REG_FREF_MON, 16'h0, 1, {FN_READ, v});
        op(dev_addr_i, FN_READ, REG_FOUT_MON, 16'h0, 1,
            {FN_READ, 16'((32'(v_calc_i) + 32'h5) / TEN)});
        op(dev_addr_i, FN_WRITE, REG_SKIP1, 16'h9c40, 1,
            {FN_WRITE, 16'h9c40});
        cmp("skip", 32'h9c40, 32'(skip_freq_one_o));
        rnd = nxt(rnd);
        v = 16'(rnd % BCAST_FULL);
        op(ADDR_BCAST, FN_WRITE, REG_FREQ, v, 0, 24'h0);
        cmp("bfreq", 32'((64'(v) * max_freq_i + BCAST_HALF) / BCAST_FULL),
            32'(freq_cmd_o));
        op(dev_addr_i, FN_WRITE, REG_UNIT, 16'h2, 1, {FN_WRITE, 16'h2});
        v = v >> 1;
        op(dev_addr_i, FN_WRITE, REG_FREQ, v, 1, {FN_WRITE, v});
        cmp("ufreq", 32'((64'(v) * max_freq_i + BCAST_HALF) / BCAST_FULL),
            32'(freq_cmd_o));
        op(dev_addr_i, FN_WRITE, REG_UNIT, 16'h4, 1,
            {8'h90, 8'h00, ERR_DATA});
        op(dev_addr_i, FN_WRITE, REG_OVR, {13'h0, rnd[2:0]}, 1,
            {FN_WRITE, 13'h0, rnd[2:0]});
        cmp("oterm", 32'({out_func_i[2:1], rnd[0]}), 32'(out_term_o));
        op(dev_addr_i, 8'h08, REG_RUN, 16'h0, 1, {8'h88, 8'h00, ERR_FUNC});
        op(dev_addr_i, FN_READ, 16'h0004, 16'h0, 1, {8'h83, 8'h00, ERR_REG});
        op(dev_addr_i, FN_WRITE, 16'h0005, 16'h0, 0, 24'h0);
        cmp("refused", 32'h1, 32'(st[ST_REFUSED]));
        op(ADDR_MAX + 8'h01, FN_READ, REG_RUN, 16'h0, 0, 24'h0);
        cmp("tmo", 32'h1, 32'(st[ST_TMO]));
        wb(1'b0, 8'h20, 32'h0);
        cmp("unmapped", 32'h0, rdat);
        conclude();
    end
endmodule
